// ==== rtl/gsc_defs.svh ====
// offsets, field positions, characters and sizes of the gauge command block
// assumes inclusion by bare name from the package and the testbench
// Contract
// - setup lock: 0 off default, 1 on
// - offset correction: linear sensors, three values
// - correction codes: off, on, measure, zero
// - three signed offsets, default zero, read/write
// - firmware version query read-only, one field
// - channel query: status code then pressure
// - second and third channel queries alike
// - all-channel query: six fields in order
// - range extension flag per sensor, default off
// - interface reset with 1 flushes input buffer
// - answer after reset lists queued errors
// - interface reset returns to measurement mode
// - error codes 0 to 14
`ifndef GSC_DEFS_SVH
`define GSC_DEFS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define GSC_ADR_STATUS 4'h0
`define GSC_ADR_ERRQ 4'h4
`define GSC_ADR_MODE 4'h8
`define GSC_ST_LOCK 0
`define GSC_ST_OCOR 1
`define GSC_ST_PRE 7
`define GSC_ST_MODE 10
`define GSC_ST_ECNT 11

// ----------------------------------------------------------------
// characters and command codes
// ----------------------------------------------------------------
`define GSC_CH_ACK 8'h06
`define GSC_CH_NAK 8'h15
`define GSC_CH_ENQ 8'h05
`define GSC_CH_CR 8'h0D
`define GSC_CH_LF 8'h0A
`define GSC_CH_COMMA 8'h2C
`define GSC_CH_ZERO 8'h30
`define GSC_MN_LOCK 24'h4C4F43
`define GSC_MN_OCOR 24'h4F4643
`define GSC_MN_OVAL 24'h4F4644
`define GSC_MN_FW 24'h504E52
`define GSC_MN_PQ1 24'h505231
`define GSC_MN_PQ2 24'h505232
`define GSC_MN_PQ3 24'h505233
`define GSC_MN_PQA 24'h505258
`define GSC_MN_PRE 24'h505245
`define GSC_MN_IRES 24'h524553

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define GSC_NUM_CHARS 11
`define GSC_NUM_ZERO 88'h2B302E30303030452B3030
`define GSC_FW_CHARS 9
`define GSC_TXB 48
`define GSC_ERR_MAX 4'hE
`define GSC_ERR_DEPTH 4

`endif

// ==== rtl/gsc_pkg.sv ====
// types shared by the gauge command block
// assumes the defs header is on the include path
package gsc_pkg;
`include "gsc_defs.svh"

   // one serial byte with its valid flag
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } gsc_byte_t;

   // a number as eleven ascii chars, sign.mantissa E sign exponent
   typedef logic [8*`GSC_NUM_CHARS-1:0] gsc_num_t;

   // readings from the measurement side
   typedef struct packed {
      logic [2:0][2:0] status;
      gsc_num_t [2:0] value;
   } gsc_meas_t;

   typedef enum logic [3:0] {
      GSC_C_NONE = 4'b0000,
      GSC_C_LOCK = 4'b0001,
      GSC_C_OCOR = 4'b0010,
      GSC_C_OVAL = 4'b0011,
      GSC_C_FW = 4'b0100,
      GSC_C_PQ1 = 4'b0101,
      GSC_C_PQ2 = 4'b0110,
      GSC_C_PQ3 = 4'b0111,
      GSC_C_PQA = 4'b1000,
      GSC_C_PRE = 4'b1001,
      GSC_C_IRES = 4'b1010
   } gsc_cmd_t;
endpackage

// ==== rtl/gsc_err_queue.sv ====
// queue of pending error codes, read out all at once
// assumes the caller filters codes and clears after read-out
`timescale 1ns/10ps
module gsc_err_queue
   import gsc_pkg::*;
#(
   parameter int DEPTH = `GSC_ERR_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // push and clear
   input wire logic push_i,
   input wire logic [3:0] code_i,
   input wire logic clear_i,
   // contents
   output logic [DEPTH-1:0][3:0] codes_o,
   output logic [CW-1:0] count_o
);
   wire full = (count_o == CW'(DEPTH));

   // a push in the clearing cycle survives the clear; a full queue drops pushes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= '0;
         codes_o <= '0;
      end else if (clear_i) begin
         codes_o[0] <= code_i;
         count_o <= push_i ? CW'(1) : '0;
      end else if (push_i && !full) begin
         codes_o[count_o] <= code_i;
         count_o <= count_o + CW'(1);
      end
   end
endmodule

// ==== rtl/gsc_top.sv ====
// serial command interpreter of a three-channel gauge controller
// assumes bytes arrive already deframed, one per valid/ready transfer
`timescale 1ns/10ps
module gsc_top
   import gsc_pkg::*;
#(
   parameter logic [8*`GSC_FW_CHARS-1:0] FW_ID = 72'h3030302D3030302D41, // arbitrary value
   parameter int EDEPTH = `GSC_ERR_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial byte streams
   input wire gsc_byte_t rx_i,
   output logic rx_ready_o,
   output gsc_byte_t tx_o,
   input wire logic tx_ready_i,
   output logic flush_o,
   // measurement side
   input wire gsc_meas_t meas_i,
   output logic lock_o,
   output logic [2:0] ocor_on_o,
   output logic [2:0] zero_adj_o,
   output logic [2:0] range_ext_o,
   output logic test_mode_o
);
   localparam int ECW = $clog2(EDEPTH + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   gsc_num_t fld_reg [0:3];
   logic [3:0] flen_reg [0:3];
   logic [1:0] fi_reg;
   logic bad_reg;
   gsc_cmd_t last_cmd_reg;
   logic lock_reg;
   logic [1:0] ocor_reg [0:2];
   gsc_num_t ofs_reg [0:2];
   logic [2:0] pre_reg;
   logic mode_reg;
   logic [2:0] zero_adj_reg;
   logic flush_reg;
   logic [7:0] tx_buf [0:`GSC_TXB-1];
   logic [5:0] tx_cnt_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [EDEPTH-1:0][3:0] err_codes;
   logic [ECW-1:0] err_cnt;
   logic [7:0] rsp [0:`GSC_TXB-1];
   logic [5:0] n;

   function automatic logic [7:0] dch(input logic [3:0] d);
      return `GSC_CH_ZERO + {4'h0, d};
   endfunction

   function automatic logic [7:0] nch(input gsc_num_t v, input int k);
      return v[8*(`GSC_NUM_CHARS-1-k) +: 8];
   endfunction

   // ----------------------------------------------------------------
   // receive decode
   // ----------------------------------------------------------------
   wire [7:0] c = rx_i.data;
   wire rx_take = rx_i.valid && rx_ready_o;
   wire is_cr = (c == `GSC_CH_CR);
   wire is_enq = (c == `GSC_CH_ENQ);
   wire is_comma = (c == `GSC_CH_COMMA);
   wire is_lf = (c == `GSC_CH_LF);
   wire line_end = rx_take && is_cr;
   wire enq_take = rx_take && is_enq;
   wire [3:0] fl_cur = flen_reg[fi_reg];
   wire [23:0] mn = fld_reg[0][87:64];
   wire [1:0] np = fi_reg;
   wire name_ok = (flen_reg[0] == 4'h3);

   // single-digit parameter of field k, and whether it is one
   wire [3:0] dg1 = fld_reg[1][83:80];
   wire [3:0] dg2 = fld_reg[2][83:80];
   wire [3:0] dg3 = fld_reg[3][83:80];
   wire d1 = (flen_reg[1] == 4'h1) && (fld_reg[1][87:84] == 4'h3) && (dg1 < 4'hA);
   wire d2 = (flen_reg[2] == 4'h1) && (fld_reg[2][87:84] == 4'h3) && (dg2 < 4'hA);
   wire d3 = (flen_reg[3] == 4'h1) && (fld_reg[3][87:84] == 4'h3) && (dg3 < 4'hA);
   wire three_d = (np == 2'd3) && d1 && d2 && d3;
   wire n11 = (flen_reg[1] == 4'hB) && (flen_reg[2] == 4'hB) && (flen_reg[3] == 4'hB);

   // mnemonic lookup
   wire gsc_cmd_t cmd_id = !name_ok ? GSC_C_NONE :
      (mn == `GSC_MN_LOCK) ? GSC_C_LOCK : (mn == `GSC_MN_OCOR) ? GSC_C_OCOR :
      (mn == `GSC_MN_OVAL) ? GSC_C_OVAL : (mn == `GSC_MN_FW) ? GSC_C_FW :
      (mn == `GSC_MN_PQ1) ? GSC_C_PQ1 : (mn == `GSC_MN_PQ2) ? GSC_C_PQ2 :
      (mn == `GSC_MN_PQ3) ? GSC_C_PQ3 : (mn == `GSC_MN_PQA) ? GSC_C_PQA :
      (mn == `GSC_MN_PRE) ? GSC_C_PRE : (mn == `GSC_MN_IRES) ? GSC_C_IRES : GSC_C_NONE;

   // parameter count and form per command; no parameters means a query
   logic form_ok;
   always_comb begin
      unique case (cmd_id)
         GSC_C_LOCK: form_ok = (np == 2'd0) || ((np == 2'd1) && d1 && (dg1 < 4'h2));
         GSC_C_OCOR: form_ok = (np == 2'd0) || (three_d && (dg1 < 4'h4) && (dg2 < 4'h4) && (dg3 < 4'h4));
         GSC_C_OVAL: form_ok = (np == 2'd0) || ((np == 2'd3) && n11);
         GSC_C_PRE: form_ok = (np == 2'd0) || (three_d && (dg1 < 4'h2) && (dg2 < 4'h2) && (dg3 < 4'h2));
         GSC_C_IRES: form_ok = (np == 2'd0) || ((np == 2'd1) && d1 && (dg1 == 4'h1));
         GSC_C_FW, GSC_C_PQ1, GSC_C_PQ2, GSC_C_PQ3, GSC_C_PQA: form_ok = (np == 2'd0);
         default: form_ok = 1'b0;
      endcase
   end

   wire cmd_ok = line_end && !bad_reg && form_ok;
   wire cmd_bad = line_end && !(!bad_reg && form_ok);
   wire do_set = cmd_ok && (np != 2'd0);
   wire ires_do = do_set && (cmd_id == GSC_C_IRES);
   wire load_ans = enq_take;
   wire err_clear = load_ans && (last_cmd_reg == GSC_C_IRES);

   // ----------------------------------------------------------------
   // line assembly into fields
   // ----------------------------------------------------------------
   // a field that overflows or a fifth field spoils the line until CR
   always_ff @(posedge clk_i) begin
      if (rst_i || ires_do || line_end) begin
         fi_reg <= 2'd0;
         bad_reg <= 1'b0;
         flen_reg <= '{default: 4'h0};
      end else if (rx_take && is_comma) begin
         if (fi_reg == 2'd3) bad_reg <= 1'b1;
         else fi_reg <= fi_reg + 2'd1;
      end else if (rx_take && !is_lf && !is_enq) begin
         if (fl_cur == 4'hB) bad_reg <= 1'b1;
         else flen_reg[fi_reg] <= fl_cur + 4'h1;
      end
   end

   // field characters; contents beyond a field's length are don't-care
   always_ff @(posedge clk_i) begin
      if (rx_take && !is_comma && !is_lf && !is_enq && !is_cr && fl_cur != 4'hB) begin
         fld_reg[fi_reg][8*(`GSC_NUM_CHARS-1-int'(fl_cur)) +: 8] <= c;
      end
   end

   // ----------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------
   wire [3:0] dgk [0:2] = '{dg1, dg2, dg3};
   wire wb_req = wb_cyc_i && wb_stb_i;
   wire wb_wr = wb_req && wb_we_i && ack_reg && wb_sel_i[0];
   wire err_push = wb_wr && (wb_adr_i == `GSC_ADR_ERRQ) &&
      (wb_dat_i[3:0] != 4'h0) && (wb_dat_i[3:0] <= `GSC_ERR_MAX);

   // settings change only on a command with parameters, at the same edge that loads the ACK; mode_reg also on a write to the mode register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_reg <= 1'b0;
         ocor_reg <= '{default: 2'd0};
         ofs_reg <= '{default: `GSC_NUM_ZERO};
         pre_reg <= 3'b000;
         mode_reg <= 1'b0;
         zero_adj_reg <= 3'b000;
         flush_reg <= 1'b0;
         last_cmd_reg <= GSC_C_NONE;
      end else begin
         zero_adj_reg <= 3'b000;
         flush_reg <= ires_do;
         if (cmd_ok) last_cmd_reg <= cmd_id;
         if (wb_wr && wb_adr_i == `GSC_ADR_MODE) mode_reg <= wb_dat_i[0];
         if (ires_do) mode_reg <= 1'b0;
         if (do_set && cmd_id == GSC_C_LOCK) lock_reg <= dg1[0];
         for (int k = 0; k < 3; k++) begin
            if (do_set && cmd_id == GSC_C_PRE) pre_reg[k] <= dgk[k][0];
            if (do_set && cmd_id == GSC_C_OVAL) ofs_reg[k] <= fld_reg[k+1];
            if (do_set && cmd_id == GSC_C_OCOR) begin
               // code 2 takes the present reading as offset and leaves correction on
               ocor_reg[k] <= (dgk[k][1:0] == 2'd2) ? 2'd1 : dgk[k][1:0];
               if (dgk[k][1:0] == 2'd2) ofs_reg[k] <= meas_i.value[k];
               zero_adj_reg[k] <= (dgk[k][1:0] == 2'd3);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // answer composition
   // ----------------------------------------------------------------
   // every field is followed by a comma; the last comma becomes CR
   always_comb begin
      rsp = '{default: 8'h00};
      n = 6'd0;
      unique case (last_cmd_reg)
         GSC_C_LOCK: begin
            rsp[0] = dch({3'b000, lock_reg});
            rsp[1] = `GSC_CH_COMMA;
            n = 6'd2;
         end
         GSC_C_OCOR, GSC_C_PRE: begin
            for (int k = 0; k < 3; k++) begin
               rsp[2*k] = (last_cmd_reg == GSC_C_OCOR) ? dch({2'b00, ocor_reg[k]}) : dch({3'b000, pre_reg[k]});
               rsp[2*k+1] = `GSC_CH_COMMA;
            end
            n = 6'd6;
         end
         GSC_C_OVAL: begin
            for (int k = 0; k < 3; k++) begin
               for (int j = 0; j < `GSC_NUM_CHARS; j++) rsp[12*k+j] = nch(ofs_reg[k], j);
               rsp[12*k+11] = `GSC_CH_COMMA;
            end
            n = 6'd36;
         end
         GSC_C_FW: begin
            for (int j = 0; j < `GSC_FW_CHARS; j++) rsp[j] = FW_ID[8*(`GSC_FW_CHARS-1-j) +: 8];
            rsp[`GSC_FW_CHARS] = `GSC_CH_COMMA;
            n = 6'(`GSC_FW_CHARS + 1);
         end
         GSC_C_PQ1, GSC_C_PQ2, GSC_C_PQ3: begin
            // channel index from the command code: 0, 1 or 2
            rsp[0] = dch({1'b0, meas_i.status[last_cmd_reg - GSC_C_PQ1]});
            rsp[1] = `GSC_CH_COMMA;
            for (int j = 0; j < `GSC_NUM_CHARS; j++) rsp[2+j] = nch(meas_i.value[last_cmd_reg - GSC_C_PQ1], j);
            rsp[13] = `GSC_CH_COMMA;
            n = 6'd14;
         end
         GSC_C_PQA: begin
            for (int k = 0; k < 3; k++) begin
               rsp[14*k] = dch({1'b0, meas_i.status[k]});
               rsp[14*k+1] = `GSC_CH_COMMA;
               for (int j = 0; j < `GSC_NUM_CHARS; j++) rsp[14*k+2+j] = nch(meas_i.value[k], j);
               rsp[14*k+13] = `GSC_CH_COMMA;
            end
            n = 6'd42;
         end
         GSC_C_IRES: begin
            // an empty queue reports the single code for no error
            if (err_cnt == '0) begin
               rsp[0] = `GSC_CH_ZERO;
               rsp[1] = `GSC_CH_COMMA;
               n = 6'd2;
            end
            for (int i = 0; i < EDEPTH; i++) begin
               if (ECW'(i) < err_cnt) begin
                  if (err_codes[i] > 4'h9) begin
                     rsp[n] = dch(4'h1);
                     rsp[n+1] = dch(err_codes[i] - 4'hA);
                     n = n + 6'd2;
                  end else begin
                     rsp[n] = dch(err_codes[i]);
                     n = n + 6'd1;
                  end
                  rsp[n] = `GSC_CH_COMMA;
                  n = n + 6'd1;
               end
            end
         end
         GSC_C_NONE: begin
            rsp[0] = `GSC_CH_COMMA;
            n = 6'd1;
         end
         default: begin
            rsp[0] = `GSC_CH_COMMA;
            n = 6'd1;
         end
      endcase
      rsp[n-6'd1] = `GSC_CH_CR;
      rsp[n] = `GSC_CH_LF;
   end

   // ----------------------------------------------------------------
   // transmit shifter
   // ----------------------------------------------------------------
   // input stalls while anything is being sent, so loads never collide
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_cnt_reg <= 6'd0;
         tx_buf <= '{default: 8'h00};
      end else if (load_ans) begin
         tx_buf <= rsp;
         tx_cnt_reg <= n + 6'd1;
      end else if (cmd_ok || cmd_bad) begin
         tx_buf <= '{0: cmd_ok ? `GSC_CH_ACK : `GSC_CH_NAK, 1: `GSC_CH_CR, 2: `GSC_CH_LF, default: 8'h00};
         tx_cnt_reg <= 6'd3;
      end else if (tx_o.valid && tx_ready_i) begin
         for (int i = 0; i < `GSC_TXB - 1; i++) tx_buf[i] <= tx_buf[i+1];
         tx_buf[`GSC_TXB-1] <= 8'h00;
         tx_cnt_reg <= tx_cnt_reg - 6'd1;
      end
   end

   assign tx_o.valid = (tx_cnt_reg != 6'd0);
   assign tx_o.data = tx_buf[0];
   assign rx_ready_o = (tx_cnt_reg == 6'd0);

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   // unmapped reads give zero and unmapped writes are ignored, both acked
   wire [31:0] st_word = {{(32-`GSC_ST_ECNT-ECW){1'b0}}, err_cnt, mode_reg, pre_reg,
      ocor_reg[2], ocor_reg[1], ocor_reg[0], lock_reg};
   wire [31:0] rd_mux = (wb_adr_i == `GSC_ADR_STATUS) ? st_word :
      (wb_adr_i == `GSC_ADR_MODE) ? {31'h0, mode_reg} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end else begin
         ack_reg <= wb_req && !ack_reg;
         if (wb_req && !ack_reg) dat_reg <= rd_mux;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   gsc_err_queue #(.DEPTH(EDEPTH), .CW(ECW)) u_errq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(err_push),
      .code_i(wb_dat_i[3:0]),
      .clear_i(err_clear),
      .codes_o(err_codes),
      .count_o(err_cnt)
   );

   // outputs
   assign lock_o = lock_reg;
   assign ocor_on_o = {ocor_reg[2] != 2'd0, ocor_reg[1] != 2'd0, ocor_reg[0] != 2'd0};
   assign zero_adj_o = zero_adj_reg;
   assign range_ext_o = pre_reg;
   assign test_mode_o = mode_reg;
   assign flush_o = flush_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_reply;
      cmd_ok |=> tx_o.valid && tx_o.data == `GSC_CH_ACK && tx_cnt_reg == 6'd3;
   endproperty
   a_ack_reply: assert property (p_ack_reply) else $error("no ACK after command");

   property p_query_keeps;
      cmd_ok && np == 2'd0 |=> $stable(lock_reg) && $stable(pre_reg) && $stable(ocor_reg[0]);
   endproperty
   a_query_keeps: assert property (p_query_keeps) else $error("query changed a setting");

   property p_lock_set;
      do_set && cmd_id == GSC_C_LOCK |=> lock_reg == $past(dg1[0]) ##1 $stable(lock_reg) || cmd_ok;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not stored");

   property p_measure;
      do_set && cmd_id == GSC_C_OCOR && dg1 == 4'h2 |=> ocor_reg[0] == 2'd1 && ofs_reg[0] == $past(meas_i.value[0]);
   endproperty
   a_measure: assert property (p_measure) else $error("offset measure failed");

   property p_ofs_default;
      $fell(rst_i) |-> ofs_reg[1] == `GSC_NUM_ZERO && ocor_reg[2] == 2'd0 && !lock_reg;
   endproperty
   a_ofs_default: assert property (p_ofs_default) else $error("bad defaults");

   property p_pq_status;
      enq_take && last_cmd_reg == GSC_C_PQ2 |=> tx_o.data == dch({1'b0, $past(meas_i.status[1])}) ##1 !tx_o.valid || tx_o.data == `GSC_CH_COMMA || !$past(tx_ready_i);
   endproperty
   a_pq_status: assert property (p_pq_status) else $error("wrong status char");

   property p_pre_set;
      do_set && cmd_id == GSC_C_PRE |=> pre_reg == {$past(dg3[0]), $past(dg2[0]), $past(dg1[0])};
   endproperty
   a_pre_set: assert property (p_pre_set) else $error("range flags not stored");

   property p_flush;
      ires_do |=> flush_o && fi_reg == 2'd0 ##1 !flush_o;
   endproperty
   a_flush: assert property (p_flush) else $error("flush pulse wrong");

   property p_err_drain;
      err_clear && !err_push |=> err_cnt == '0 && tx_cnt_reg == $past(n) + 6'd1;
   endproperty
   a_err_drain: assert property (p_err_drain) else $error("error queue not drained");

   property p_mode_back;
      ires_do |=> !mode_reg && !test_mode_o;
   endproperty
   a_mode_back: assert property (p_mode_back) else $error("mode not cleared");

   property p_err_range;
      wb_wr && wb_adr_i == `GSC_ADR_ERRQ && wb_dat_i[3:0] > `GSC_ERR_MAX |=> err_cnt == $past(err_cnt);
   endproperty
   a_err_range: assert property (p_err_range) else $error("bad error code queued");
endmodule

// ==== tb/gsc_host.sv ====
// host model on the serial byte side of the command block
// assumes the bench calls put() and empties q itself
`timescale 1ns/10ps
module gsc_host
   import gsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // byte streams
   output gsc_byte_t tx_o,
   input wire logic rx_ready_i,
   input wire gsc_byte_t rx_i,
   output logic tx_ready_o
);
   logic slow = 1'b0;
   logic stuck = 1'b0;
   logic [7:0] q[$];
   initial tx_o = 9'h055;
   initial tx_ready_o = 1'b1;
   // -------------
   // send and take
   // -------------
   // hold the byte up to the edge that sees ready; then show its inverse
   task automatic put(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk_i);
      tx_o <= {1'b1, b};
      do begin
         @(negedge clk_i);
         n++;
      end while (rx_ready_i !== 1'b1 && n < 400);
      if (n >= 400) stuck = 1'b1;
      @(posedge clk_i);
      tx_o <= {1'b0, ~b};
   endtask
   // slow mode stalls every other cycle to exercise held tx bytes
   always @(posedge clk_i) begin
      tx_ready_o <= !slow | !tx_ready_o;
      if (!rst_i && rx_i.valid && tx_ready_o) q.push_back(rx_i.data);
   end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the gauge command block
// assumes the host model drives the serial side
`timescale 1ns/10ps
`include "gsc_defs.svh"
module tb;
   import gsc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, flushed = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, rx_ready_o, tx_ready_i, flush_o, lock_o, test_mode_o;
   logic [2:0] ocor_on_o, zero_adj_o, range_ext_o;
   logic [2:0] zadj = 3'b000;
   gsc_byte_t rx_i, tx_o;
   gsc_meas_t meas_i;
   int err_count = 0, tests_run = 0;
   gsc_top dut(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .rx_ready_o(rx_ready_o), .tx_o(tx_o),
      .tx_ready_i(tx_ready_i), .flush_o(flush_o), .meas_i(meas_i), .lock_o(lock_o),
      .ocor_on_o(ocor_on_o), .zero_adj_o(zero_adj_o), .range_ext_o(range_ext_o), .test_mode_o(test_mode_o));
   gsc_host host(.clk_i(clk_i), .rst_i(rst_i), .tx_o(rx_i), .rx_ready_i(rx_ready_o), .rx_i(tx_o),
      .tx_ready_o(tx_ready_i));
   // clock; flush is a one-cycle pulse, so latch it
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (flush_o === 1'b1) flushed <= 1'b1;
   // zero adjust is a one-cycle pulse per channel, so gather it
   always @(posedge clk_i) zadj <= zadj | zero_adj_o;
   // ------------
   // tasks
   // ------------
   task automatic conclude();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_s(input string n, input string e, input string g);
      tests_run++;
      if (e != g) begin
         $display("unexpected %s exp %s got %s", n, e, g);
         err_count++;
      end
   endtask
   task automatic chk_v(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (e !== g) begin
         $display("unexpected %s exp %h got %h", n, e, g);
         err_count++;
      end
   endtask
   // classic cycle; data taken at the edge that samples ack
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(negedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // let the write settle before anyone looks at the outputs
      @(negedge clk_i);
      if (n >= 20) begin
         err_count++;
         conclude();
      end
   endtask
   // one answer line, up to its line feed
   task automatic rsp(output string s);
      int n;
      n = 0;
      while (!(host.q.size() > 0 && host.q[$] == 8'h0A) && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      s = "";
      foreach (host.q[i]) s = {s, string'(host.q[i])};
      host.q.delete();
      if (n >= 400 || host.stuck) begin
         err_count++;
         conclude();
      end
   endtask
   // mnemonic, then parameters; an optional LF follows the CR
   task automatic cmd(input logic [23:0] m, input string p, input string a, input string k = "\006\r\n");
      string s, l;
      l = {string'(m), p};
      foreach (l[i]) host.put(l[i]);
      host.put(8'h0D);
      host.put(8'h0A);
      rsp(s);
      chk_s(l, k, s);
      host.put(8'h05);
      rsp(s);
      chk_s(l, {a, "\r\n"}, s);
      $display("done %s", l);
   endtask
   // ------------
   // sequence
   // ------------
   initial begin
      meas_i = {3'h3, 3'h0, 3'h7, "+9.9990E+02", "-2.5000E+01", "+1.0000E-03"};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      chk_v("status", 32'h0, rd);
      wb(1'b0, 4'hC, 32'h0);
      chk_v("unmapped", 32'h0, rd);
      cmd(`GSC_MN_LOCK, ",1", "1");
      cmd(`GSC_MN_LOCK, "", "1");
      chk_v("lock", 32'h1, lock_o);
      cmd(24'h58595A, "", "1", "\025\r\n");
      cmd(`GSC_MN_OCOR, ",1,0,3", "1,0,3");
      chk_v("offset corr", 32'h5, ocor_on_o);
      chk_v("zero adj", 32'h4, zadj);
      cmd(`GSC_MN_OVAL, "", "+0.0000E+00,+0.0000E+00,+0.0000E+00");
      cmd(`GSC_MN_OCOR, ",2,0,3", "1,0,3");
      cmd(`GSC_MN_OVAL, "", "+1.0000E-03,+0.0000E+00,+0.0000E+00");
      cmd(`GSC_MN_OVAL, ",-1.5000E-02,+0.0000E+00,+2.0000E+01", "-1.5000E-02,+0.0000E+00,+2.0000E+01");
      cmd(`GSC_MN_FW, "", "000-000-A");
      cmd(`GSC_MN_PQ1, "", "7,+1.0000E-03");
      cmd(`GSC_MN_PQ2, "", "0,-2.5000E+01");
      cmd(`GSC_MN_PQ3, "", "3,+9.9990E+02");
      host.slow = 1'b1;
      cmd(`GSC_MN_PQA, "", "7,+1.0000E-03,0,-2.5000E+01,3,+9.9990E+02");
      host.slow = 1'b0;
      cmd(`GSC_MN_PRE, ",1,0,1", "1,0,1");
      chk_v("range", 32'h5, range_ext_o);
      wb(1'b1, 4'h4, 32'h9);
      wb(1'b1, 4'h4, 32'hF);
      wb(1'b1, 4'h4, 32'hE);
      wb(1'b1, 4'h8, 32'h1);
      chk_v("mode", 32'h1, test_mode_o);
      wb(1'b0, 4'h8, 32'h0);
      chk_v("mode reg", 32'h1, rd);
      wb(1'b0, 4'h0, 32'h0);
      chk_v("status", 32'h0000_16E3, rd);
      cmd(`GSC_MN_IRES, ",1", "9,14");
      chk_v("flush", 32'h1, flushed);
      chk_v("mode", 32'h0, test_mode_o);
      cmd(`GSC_MN_IRES, "", "0");
      conclude();
   end
endmodule
